/* pkg/aux_seq_pkg.sv */
package aux_seq_pkg;
    // Printed offsets are not byte offsets: these are word indices.
    localparam logic [7:0]  IDX_FILTER_CFG  = 8'h8C;
    localparam logic [7:0]  IDX_SPARE       = 8'h8D;
    localparam logic [7:0]  IDX_OFFSET_TRIM = 8'h8E;
    localparam logic [7:0]  IDX_GAIN_TRIM   = 8'h8F;
    localparam logic [7:0]  IDX_CONTROL     = 8'hA0;
    localparam logic [7:0]  IDX_STATUS      = 8'hA1;
    localparam logic [7:0]  IDX_RESULT      = 8'hA2;
    localparam logic [7:0]  IDX_STEP_EN     = 8'hA3;
    localparam logic [7:0]  IDX_RAW         = 8'hA4;

    localparam logic [15:0] FILTER_CFG_RST  = 16'h0000;
    localparam logic [15:0] FILTER_CFG_MASK = 16'hC703;
    localparam logic [15:0] SPARE_RST       = 16'h0000;
    localparam logic [15:0] SPARE_MASK      = 16'h00FF;
    localparam logic [15:0] TRIM_RST        = 16'h0000;
    localparam logic [3:0]  STEP_EN_RST     = 4'hF;

    localparam int MODE_HI    = 15;
    localparam int MODE_LO    = 14;
    localparam int DELAY_HI   = 10;
    localparam int DELAY_LO   = 8;
    localparam int OSR_HI     = 1;
    localparam int OSR_LO     = 0;
    localparam int CTL_EN     = 0;
    localparam int CTL_TRIG   = 1;
    localparam int CTL_STBY   = 2;
    localparam int CTL_GAIN_LO = 4;
    localparam int CTL_GAIN_HI = 5;

    localparam logic [1:0]  MODE_SW_SINGLE = 2'b00;
    localparam logic [1:0]  MODE_HW_SINGLE = 2'b01;

    localparam logic [12:0] SETTLE_0 = 13'h0010;
    localparam logic [12:0] SETTLE_1 = 13'h0040;
    localparam logic [12:0] SETTLE_2 = 13'h0080;
    localparam logic [12:0] SETTLE_3 = 13'h0100;
    localparam logic [12:0] SETTLE_4 = 13'h0200;
    localparam logic [12:0] SETTLE_5 = 13'h0400;
    localparam logic [12:0] SETTLE_6 = 13'h0800;
    localparam logic [12:0] SETTLE_7 = 13'h1000;

    localparam logic [12:0] CONV_0 = 13'h0180;
    localparam logic [12:0] CONV_1 = 13'h0200;
    localparam logic [12:0] CONV_2 = 13'h0300;
    localparam logic [12:0] CONV_3 = 13'h0500;

    localparam logic [15:0] FULL_POS = 16'h7FFF;
    localparam logic [15:0] FULL_NEG = 16'h8000;
endpackage

/* verilog/aux_corrector.sv */
module aux_corrector
    import aux_seq_pkg::*;
(
    // Raw sample and trims
    input  wire logic [15:0] raw,
    input  wire logic [15:0] offset_word,
    input  wire logic [15:0] gain_word,
    input  wire logic [1:0]  gain_sel,
    // Corrected sample
    output logic      [15:0] corrected
);
    logic signed [17:0] off_scaled;
    logic signed [18:0] diff;
    logic signed [17:0] factor;
    logic signed [36:0] prod;
    logic signed [20:0] shifted;

    // At gain 2 and 4 the offset step is half, so the word counts half codes.
    always_comb begin
        if (gain_sel == 2'b00) begin
            off_scaled = 18'($signed(offset_word)) <<< 1;
        end else begin
            off_scaled = 18'($signed(offset_word));
        end
        diff    = 19'($signed({raw[15], raw, 1'b0})) - 19'(off_scaled);
        factor  = 18'sh10000 + 18'($signed(gain_word));
        prod    = 37'(diff) * 37'(factor);
        shifted = 21'(prod >>> 17);
        if (shifted > 21'sd32767) begin
            corrected = FULL_POS;
        end else if (shifted < -21'sd32768) begin
            corrected = FULL_NEG;
        end else begin
            corrected = shifted[15:0];
        end
    end
endmodule

/* verilog/aux_sequencer.sv */
// Summary of operation
// - Trigger write aborts and restarts the sequence.
// - Mode 01b: pass on ready-fall or trigger.
// - Ready-fall during running sequence is ignored.
// - Modes 10b, 11b run continuously after trigger.
// - Settle delay 16 to 4096 clocks per step.
// - Oversampling field selects ratio 64 to 512.
// - Conversion lasts 384, 512, 768, 1280 clocks.
// - Offset word two's complement, full step.
// - Offset step halved at gains 2, 4.
// - Spare register stores bits, no effect.
// - Cleared gain word gives unity gain.
// - Disable or standby clears results and counter.
//
// Our own choice: register access over APB.
module aux_sequencer
    import aux_seq_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Primary converter ready, from its own timing domain
    input  wire logic        primary_conv_ready_n,
    // Converter core
    input  wire logic [15:0] aux_raw_sample,
    output logic             aux_conv_busy,
    output logic [1:0]       aux_step_counter,
    output logic [1:0]       aux_oversampling_select,
    output logic [1:0]       aux_gain_select
);
    typedef enum logic [1:0] {IDLE, SETTLE, CONVERT} seq_state_e;

    logic [15:0] filter_cfg_q;
    logic [15:0] spare_q;
    logic [15:0] offset_trim_q;
    logic [15:0] gain_trim_q;
    logic [7:0]  control_q;
    logic [3:0]  step_en_q;
    logic [15:0] result_q [4];
    logic [15:0] raw_last_q;
    logic [1:0]  step_q;
    logic [12:0] count_q;
    logic        pass_done_q;
    logic [2:0]  rdy_sync_q;
    logic        rdy_level_q;
    seq_state_e  state_q;

    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic        mapped;
    logic        trig;
    logic        rdy_fall;
    logic        enable;
    logic        cleared;
    logic [1:0]  mode;
    logic [15:0] corrected;
    logic        last_step;
    logic [1:0]  next_step;
    logic        aligned;
    logic [12:0] settle_len;
    logic [12:0] conv_len;

    function automatic logic [12:0] settle_count(input logic [2:0] sel);
        case (sel)
            3'h0:    settle_count = SETTLE_0;
            3'h1:    settle_count = SETTLE_1;
            3'h2:    settle_count = SETTLE_2;
            3'h3:    settle_count = SETTLE_3;
            3'h4:    settle_count = SETTLE_4;
            3'h5:    settle_count = SETTLE_5;
            3'h6:    settle_count = SETTLE_6;
            default: settle_count = SETTLE_7;
        endcase
    endfunction

    function automatic logic [12:0] conv_count(input logic [1:0] sel);
        case (sel)
            2'h0:    conv_count = CONV_0;
            2'h1:    conv_count = CONV_1;
            2'h2:    conv_count = CONV_2;
            default: conv_count = CONV_3;
        endcase
    endfunction

    // Next enabled step after s, wrapping; returns s if none other.
    function automatic logic [1:0] next_enabled(input logic [1:0] s,
                                                input logic [3:0] en);
        logic [1:0] k;
        next_enabled = s;
        for (int i = 3; i >= 1; i--) begin
            k = 2'(s + 2'(i));
            if (en[k]) begin
                next_enabled = k;
            end
        end
    endfunction

    function automatic logic [1:0] first_enabled(input logic [3:0] en);
        first_enabled = 2'b00;
        for (int i = 3; i >= 0; i--) begin
            if (en[i]) begin
                first_enabled = 2'(i);
            end
        end
    endfunction

    assign aligned  = paddr[1:0] == 2'b00;
    assign wr       = psel && penable && pwrite && aligned;
    assign rd       = psel && !pwrite;
    assign idx      = paddr[9:2];
    assign pready   = 1'b1;
    assign mapped   = (idx == IDX_FILTER_CFG) || (idx == IDX_SPARE)
                   || (idx == IDX_OFFSET_TRIM) || (idx == IDX_GAIN_TRIM)
                   || (idx == IDX_CONTROL) || (idx == IDX_STATUS)
                   || (idx == IDX_RESULT) || (idx == IDX_STEP_EN)
                   || (idx == IDX_RAW);
    assign pslverr  = psel && penable && (!mapped || !aligned);
    assign trig     = wr && idx == IDX_CONTROL && pwdata[CTL_TRIG];
    assign enable   = control_q[CTL_EN];
    assign cleared  = !enable || control_q[CTL_STBY];
    assign mode     = filter_cfg_q[MODE_HI:MODE_LO];
    assign rdy_fall = rdy_level_q && !rdy_sync_q[2] && !rdy_sync_q[1];
    assign next_step = next_enabled(step_q, step_en_q);
    assign last_step = next_step <= step_q;
    assign settle_len = settle_count(filter_cfg_q[DELAY_HI:DELAY_LO]);
    assign conv_len   = conv_count(filter_cfg_q[OSR_HI:OSR_LO]);

    assign aux_conv_busy           = state_q == CONVERT;
    assign aux_step_counter        = step_q;
    assign aux_oversampling_select = filter_cfg_q[OSR_HI:OSR_LO];
    assign aux_gain_select         = control_q[CTL_GAIN_HI:CTL_GAIN_LO];

    aux_corrector aux_corrector_inst (
        .raw         (aux_raw_sample),
        .offset_word (offset_trim_q),
        .gain_word   (gain_trim_q),
        .gain_sel    (aux_gain_select),
        .corrected   (corrected)
    );

    // The ready pin is asynchronous, so it is filtered before edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_sync_q  <= 3'b111;
            rdy_level_q <= 1'b1;
        end else begin
            rdy_sync_q <= {rdy_sync_q[1:0], primary_conv_ready_n};
            if (rdy_sync_q[2] == rdy_sync_q[1]) begin
                rdy_level_q <= rdy_sync_q[2];
            end
        end
    end

    // Settings are not locked while enabled; software must disable first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_cfg_q <= FILTER_CFG_RST;
        end else if (wr && idx == IDX_FILTER_CFG) begin
            filter_cfg_q <= pwdata[15:0] & FILTER_CFG_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spare_q <= SPARE_RST;
        end else if (wr && idx == IDX_SPARE) begin
            spare_q <= pwdata[15:0] & SPARE_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_trim_q <= TRIM_RST;
        end else if (wr && idx == IDX_OFFSET_TRIM) begin
            offset_trim_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_trim_q <= TRIM_RST;
        end else if (wr && idx == IDX_GAIN_TRIM) begin
            gain_trim_q <= pwdata[15:0];
        end
    end

    // The trigger bit is not stored, so it always reads back as zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= 8'h00;
        end else if (wr && idx == IDX_CONTROL) begin
            control_q <= pwdata[7:0] & 8'h35;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_en_q <= STEP_EN_RST;
        end else if (wr && idx == IDX_STEP_EN) begin
            step_en_q <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= IDLE;
            step_q      <= 2'b00;
            count_q     <= 13'h0000;
            pass_done_q <= 1'b0;
        end else if (cleared) begin
            state_q <= IDLE;
            step_q  <= 2'b00;
            count_q <= 13'h0000;
        end else if (trig && step_en_q != 4'h0) begin
            state_q     <= SETTLE;
            step_q      <= first_enabled(step_en_q);
            count_q     <= settle_len;
            pass_done_q <= 1'b0;
        end else begin
            case (state_q)
                IDLE: begin
                    if (rdy_fall && mode == MODE_HW_SINGLE
                        && step_en_q != 4'h0) begin
                        state_q <= SETTLE;
                        step_q  <= first_enabled(step_en_q);
                        count_q <= settle_len;
                    end
                end
                SETTLE: begin
                    if (count_q <= 13'h0001) begin
                        state_q <= CONVERT;
                        count_q <= conv_len;
                    end else begin
                        count_q <= 13'(count_q - 13'h0001);
                    end
                end
                CONVERT: begin
                    if (count_q <= 13'h0001) begin
                        count_q <= settle_len;
                        if (last_step && !mode[1]) begin
                            state_q     <= IDLE;
                            pass_done_q <= 1'b1;
                        end else begin
                            state_q <= SETTLE;
                        end
                        step_q <= next_step;
                    end else begin
                        count_q <= 13'(count_q - 13'h0001);
                    end
                end
                default: state_q <= IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                result_q[i] <= 16'h0000;
            end
            raw_last_q <= 16'h0000;
        end else if (cleared) begin
            for (int i = 0; i < 4; i++) begin
                result_q[i] <= 16'h0000;
            end
            raw_last_q <= 16'h0000;
        end else if (state_q == CONVERT && count_q <= 13'h0001) begin
            result_q[step_q] <= corrected;
            raw_last_q       <= aux_raw_sample;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd && !penable) begin
            // A misaligned read is refused and returns zero.
            case (aligned ? idx : 8'h00)
                IDX_FILTER_CFG:  prdata <= {16'h0000, filter_cfg_q};
                IDX_SPARE:       prdata <= {16'h0000, spare_q};
                IDX_OFFSET_TRIM: prdata <= {16'h0000, offset_trim_q};
                IDX_GAIN_TRIM:   prdata <= {16'h0000, gain_trim_q};
                IDX_CONTROL:     prdata <= {24'h000000, control_q};
                IDX_STATUS:      prdata <= {27'h0000000, pass_done_q,
                                            step_q, state_q};
                IDX_RESULT:      prdata <= {16'h0000, result_q[paddr[11:10]]};
                IDX_STEP_EN:     prdata <= {28'h0000000, step_en_q};
                IDX_RAW:         prdata <= {16'h0000, raw_last_q};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

/* tb/aux_seq_checker.sv */
module aux_seq_checker
    import aux_seq_pkg::*;
(
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Converter
    input wire logic        aux_conv_busy,
    input wire logic [1:0]  aux_step_counter,
    input wire logic [1:0]  aux_oversampling_select,
    input wire logic [1:0]  aux_gain_select
);
    logic        acc;
    logic        cwr;
    logic [1:0]  osr_w;
    logic [1:0]  gsel_w;
    logic [12:0] conv_t;
    logic [12:0] blen_q;

    assign acc = psel && penable;
    assign cwr = acc && pwrite && paddr == 12'h280;
    assign osr_w = pwdata[1:0];
    assign gsel_w = pwdata[5:4];
    assign conv_t = aux_oversampling_select == 2'h0 ? CONV_0 :
                    aux_oversampling_select == 2'h1 ? CONV_1 :
                    aux_oversampling_select == 2'h2 ? CONV_2 : CONV_3;

    // A control write may cut a conversion short, so it is excused below.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blen_q <= 13'h0000;
        end else begin
            blen_q <= aux_conv_busy ? blen_q + 13'h0001 : 13'h0000;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_misalign: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    a_cfg_mapped: assert property (acc && paddr == 12'h230 |-> !pslverr)
        else $error("config access refused");
    a_err_rdata: assert property (
        acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read data not zero");
    a_osr_update: assert property (
        acc && pwrite && paddr == 12'h230 |=>
        aux_oversampling_select == $past(osr_w))
        else $error("oversampling field not applied");
    a_gain_update: assert property (
        cwr |=> aux_gain_select == $past(gsel_w))
        else $error("gain select not applied");
    a_disable_clear: assert property (
        cwr && !pwdata[0] |=> ##1 aux_step_counter == 2'h0)
        else $error("step counter not cleared");
    a_conv_length: assert property (
        $fell(aux_conv_busy) && !$past(cwr) && !$past(cwr, 2) |->
        blen_q == conv_t)
        else $error("conversion length wrong");
endmodule

bind aux_sequencer aux_seq_checker aux_seq_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aux_conv_busy(aux_conv_busy),
    .aux_step_counter(aux_step_counter),
    .aux_oversampling_select(aux_oversampling_select),
    .aux_gain_select(aux_gain_select)
);

/* tb/aux_sequencer_tb.sv */
module aux_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import aux_seq_pkg::*;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        rdy_n = 1'b1;
    logic [15:0] raw = 16'h0000;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, busy, errv;
    logic [1:0]  step, osr, gsel;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n;
    logic [12:0] dly [8] = '{SETTLE_0, SETTLE_1, SETTLE_2, SETTLE_3,
                             SETTLE_4, SETTLE_5, SETTLE_6, SETTLE_7};
    logic [12:0] conv [4] = '{CONV_0, CONV_1, CONV_2, CONV_3};
    // Columns: raw, offset, gain word, gain select, corrected.
    logic [15:0] cal [6][5] = '{
        '{16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h1000},
        '{16'h1000, 16'h0010, 16'h0000, 16'h0000, 16'h0FF0},
        '{16'h1000, 16'h0020, 16'h0000, 16'h0001, 16'h0FF0},
        '{16'h1000, 16'h0000, 16'h8000, 16'h0000, 16'h0800},
        '{16'h7FF0, 16'h0000, 16'h7FFF, 16'h0000, 16'h7FFF},
        '{16'h8000, 16'h0001, 16'h0000, 16'h0000, 16'h8000}};

    aux_sequencer aux_sequencer_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .primary_conv_ready_n(rdy_n),
        .aux_raw_sample(raw), .aux_conv_busy(busy),
        .aux_step_counter(step), .aux_oversampling_select(osr),
        .aux_gain_select(gsel));

    always #5 pclk = ~pclk;

    task automatic close_out();
        if (fail_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run(input logic [1:0] g);
        // Enable must already stand when the trigger is written.
        apb(1'b1, 12'h280, {26'h0, g, 4'h1});
        apb(1'b1, 12'h280, {26'h0, g, 4'h3});
        rdv = 32'h0;
        while (rdv[4] !== 1'b1) apb(1'b0, 12'h284, 32'h0);
    endtask

    task automatic t_regs();
        apb(1'b0, 12'h28C, 32'h0);
        chk(rdv, 32'hF);
        apb(1'b1, 12'h230, 32'hFFFFFFFF);
        apb(1'b0, 12'h230, 32'h0);
        chk(rdv, 32'hC703);
        apb(1'b1, 12'h234, 32'hFFFFFFFF);
        apb(1'b0, 12'h234, 32'h0);
        chk(rdv, 32'hFF);
        apb(1'b0, 12'h2F0, 32'h0);
        chk({31'h0, errv}, 32'h1);
        chk(rdv, 32'h0);
        apb(1'b0, 12'h231, 32'h0);
        chk({31'h0, errv}, 32'h1);
        chk(rdv, 32'h0);
        apb(1'b1, 12'h28C, 32'h1);
        apb(1'b1, 12'h230, 32'h0);
    endtask

    task automatic t_cal();
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'h280, 32'h0);
            raw <= cal[i][0];
            apb(1'b1, 12'h238, {16'h0, cal[i][1]});
            apb(1'b1, 12'h23C, {16'h0, cal[i][2]});
            run(cal[i][3][1:0]);
            apb(1'b0, 12'h288, 32'h0);
            chk(rdv, {16'h0, cal[i][4]});
        end
    endtask

    task automatic t_timing();
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, 12'h280, 32'h0);
            apb(1'b1, 12'h230, {21'h0, i[2:0], 6'h0, i[1:0]});
            apb(1'b1, 12'h280, 32'h1);
            apb(1'b1, 12'h280, 32'h3);
            n = 0;
            for (; busy !== 1'b1; n++) @(posedge pclk);
            chk(32'(n >= dly[i] && n <= dly[i] + 4), 32'h1);
            n = 0;
            for (; busy === 1'b1; n++) @(posedge pclk);
            chk(32'(n), {19'h0, conv[i % 4]});
        end
    endtask

    task automatic t_abort();
        apb(1'b1, 12'h280, 32'h0);
        apb(1'b1, 12'h230, 32'h0);
        apb(1'b1, 12'h280, 32'h1);
        apb(1'b1, 12'h280, 32'h3);
        repeat (100) @(posedge pclk);
        run(2'h0);
        repeat (50) @(posedge pclk);
        chk({31'h0, busy}, 32'h0);
        apb(1'b1, 12'h280, 32'h3);
        repeat (100) @(posedge pclk);
        apb(1'b1, 12'h280, 32'h3);
        apb(1'b0, 12'h284, 32'h0);
        chk({30'h0, rdv[1:0]}, 32'h1);
    endtask

    task automatic t_hw();
        apb(1'b1, 12'h280, 32'h0);
        apb(1'b1, 12'h230, 32'h4000);
        apb(1'b1, 12'h280, 32'h1);
        rdy_n <= 1'b0;
        n = 0;
        for (; busy !== 1'b1; n++) @(posedge pclk);
        chk(32'(n <= 40), 32'h1);
        rdy_n <= 1'b1;
        repeat (50) @(posedge pclk);
        rdy_n <= 1'b0;
        repeat (10) @(posedge pclk);
        chk({31'h0, busy}, 32'h1);
        rdy_n <= 1'b1;
    endtask

    task automatic t_cont();
        apb(1'b1, 12'h28C, 32'h3);
        for (int m = 2; m < 4; m++) begin
            apb(1'b1, 12'h280, 32'h0);
            apb(1'b1, 12'h230, {16'h0, m[1:0], 14'h0});
            apb(1'b1, 12'h280, 32'h1);
            apb(1'b1, 12'h280, 32'h3);
            n = 0;
            repeat (6) @(negedge busy) n++;
            @(posedge pclk);
            chk({30'h0, step}, 32'h0);
            apb(1'b0, 12'h288, 32'h0);
            chk(rdv, 32'h8000);
            // First pass is stopped by standby, second by disable.
            apb(1'b1, 12'h280, (m == 2) ? 32'h5 : 32'h0);
            apb(1'b0, 12'h288, 32'h0);
            chk({30'h0, step}, 32'h0);
            chk(rdv, 32'h0);
        end
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_cal();
        t_timing();
        t_abort();
        t_hw();
        t_cont();
        close_out();
    end
endmodule
